// *** pkg/pfc_pkg.sv ***
// constants for the port 1 flow-control register block
package pfc_pkg;
    // register map (byte address on the wishbone bus)
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] PORT1_FLOW_CONTROL_CONFIG_OFS = 12'h1a0;

    // field positions inside port1_flow_control_config
    localparam int BIT_BACKPRESSURE_EN = 6;
    localparam int BIT_DUPLEX_NOW = 5;
    localparam int BIT_PAUSE_RX_NOW = 4;
    localparam int BIT_PAUSE_TX_NOW = 3;
    localparam int BIT_PAUSE_RX_EN = 2;
    localparam int BIT_PAUSE_TX_EN = 1;
    localparam int BIT_MANUAL_SELECT = 0;
    localparam int FIELD_TOP = 6;

    // read value of the reserved upper bits
    localparam logic [31:FIELD_TOP+1] RESERVED_READ = 25'h000_0000;

    // strap vector layout
    localparam int STRAP_N = 5;
    localparam int STRAP_BACKPRESSURE = 0;
    localparam int STRAP_PAUSE_ENABLE = 1;
    localparam int STRAP_MANUAL_SELECT = 2;
    localparam int STRAP_FULL_DUPLEX = 3;
    localparam int STRAP_AUTONEG = 4;

    // duplex encoding of the status bit
    localparam logic DUPLEX_FULL = 1'b0;
    localparam logic DUPLEX_HALF = 1'b1;
endpackage

// *** hdl/pfc_resolve.sv ***
// resolves which pause directions are in force on port 1
`timescale 1ns/1ps
`default_nettype none
module pfc_resolve
    import pfc_pkg::*;
(
    input wire logic manual_select_i,
    input wire logic autoneg_en_i,
    input wire logic full_duplex_i,
    input wire logic pause_rx_en_i,
    input wire logic pause_tx_en_i,
    input wire logic an_pause_rx_i,
    input wire logic an_pause_tx_i,
    output logic duplex_now_o,
    output logic pause_rx_now_o,
    output logic pause_tx_now_o
);
    logic use_stored;

    // stored bits win when manual or negotiation is off
    assign use_stored = manual_select_i | ~autoneg_en_i;

    // pause frames only make sense in full duplex, so half duplex masks both
    always_comb begin
        duplex_now_o = full_duplex_i ? DUPLEX_FULL : DUPLEX_HALF;
        if (use_stored) begin
            pause_rx_now_o = pause_rx_en_i & full_duplex_i;
            pause_tx_now_o = pause_tx_en_i & full_duplex_i;
        end else begin
            // negotiated result, stored enables ignored
            pause_rx_now_o = an_pause_rx_i & full_duplex_i;
            pause_tx_now_o = an_pause_tx_i & full_duplex_i;
        end
    end
endmodule
`default_nettype wire

// *** hdl/pfc_regs.sv ***
// port 1 flow-control config register with wishbone slave and status
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module pfc_regs
    import pfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration strap pins
    input wire logic backpressure_strap_i,
    input wire logic pause_enable_strap_i,
    input wire logic manual_select_strap_i,
    input wire logic full_duplex_strap_i,
    input wire logic autoneg_strap_i,
    // configuration loader rewrite of the straps
    input wire logic loader_load_i,
    input wire logic loader_backpressure_i,
    input wire logic loader_pause_enable_i,
    input wire logic loader_manual_select_i,
    // link state from the phy and negotiation
    input wire logic autoneg_en_i,
    input wire logic link_full_duplex_i,
    input wire logic an_pause_rx_i,
    input wire logic an_pause_tx_i,
    // controls to the port mac
    output logic port1_backpressure_en_o,
    output logic port1_pause_rx_now_o,
    output logic port1_pause_tx_now_o,
    output logic port1_duplex_now_o
);
    logic [STRAP_N-1:0] strap_pin;
    logic [STRAP_N-1:0] strap_meta;
    logic [STRAP_N-1:0] strap_sync;
    logic port1_backpressure_en;
    logic port1_pause_rx_en;
    logic port1_pause_tx_en;
    logic port1_manual_select;
    logic port1_duplex_now;
    logic port1_pause_rx_now;
    logic port1_pause_tx_now;
    logic next_duplex_now;
    logic next_pause_rx_now;
    logic next_pause_tx_now;
    logic rst_duplex_now;
    logic rst_pause_rx_now;
    logic rst_pause_tx_now;
    logic req;
    logic hit;
    logic wr_low;
    logic [31:0] rd_word;

    assign strap_pin[STRAP_BACKPRESSURE] = backpressure_strap_i;
    assign strap_pin[STRAP_PAUSE_ENABLE] = pause_enable_strap_i;
    assign strap_pin[STRAP_MANUAL_SELECT] = manual_select_strap_i;
    assign strap_pin[STRAP_FULL_DUPLEX] = full_duplex_strap_i;
    assign strap_pin[STRAP_AUTONEG] = autoneg_strap_i;

    // two-stage synchronisers, not reset and gated only by ce_i, so reset sees settled straps
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_N; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (ce_i) begin
                    strap_meta[gi] <= strap_pin[gi];
                    strap_sync[gi] <= strap_meta[gi];
                end
            end
        end
    endgenerate

    // bus decode: a new request is one not yet acknowledged
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign hit = wb_adr_i[ADDR_W-1:2] == PORT1_FLOW_CONTROL_CONFIG_OFS[ADDR_W-1:2];
    // only byte lane 0 carries the writable field
    assign wr_low = req & wb_we_i & hit & wb_sel_i[0];

    // writable bits: reset from straps, loader beats a software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port1_backpressure_en <= strap_sync[STRAP_BACKPRESSURE];
            port1_pause_rx_en <= strap_sync[STRAP_PAUSE_ENABLE];
            port1_pause_tx_en <= strap_sync[STRAP_PAUSE_ENABLE];
            port1_manual_select <= strap_sync[STRAP_MANUAL_SELECT];
        end else if (ce_i) begin
            if (loader_load_i) begin
                port1_backpressure_en <= loader_backpressure_i;
                port1_pause_rx_en <= loader_pause_enable_i;
                port1_pause_tx_en <= loader_pause_enable_i;
                port1_manual_select <= loader_manual_select_i;
            end else if (wr_low) begin
                // status bits 5..3 and reserved bits are simply not stored
                port1_backpressure_en <= wb_dat_i[BIT_BACKPRESSURE_EN];
                port1_pause_rx_en <= wb_dat_i[BIT_PAUSE_RX_EN];
                port1_pause_tx_en <= wb_dat_i[BIT_PAUSE_TX_EN];
                port1_manual_select <= wb_dat_i[BIT_MANUAL_SELECT];
            end
        end
    end

    // reset status combines duplex, negotiation, manual and pause straps
    pfc_resolve u_rst_resolve (
        .manual_select_i(strap_sync[STRAP_MANUAL_SELECT]),
        .autoneg_en_i(strap_sync[STRAP_AUTONEG]),
        .full_duplex_i(strap_sync[STRAP_FULL_DUPLEX]),
        .pause_rx_en_i(strap_sync[STRAP_PAUSE_ENABLE]),
        .pause_tx_en_i(strap_sync[STRAP_PAUSE_ENABLE]),
        .an_pause_rx_i(strap_sync[STRAP_PAUSE_ENABLE]),
        .an_pause_tx_i(strap_sync[STRAP_PAUSE_ENABLE]),
        .duplex_now_o(rst_duplex_now),
        .pause_rx_now_o(rst_pause_rx_now),
        .pause_tx_now_o(rst_pause_tx_now)
    );

    // live status from the stored enables and the negotiated result
    pfc_resolve u_resolve (
        .manual_select_i(port1_manual_select),
        .autoneg_en_i(autoneg_en_i),
        .full_duplex_i(link_full_duplex_i),
        .pause_rx_en_i(port1_pause_rx_en),
        .pause_tx_en_i(port1_pause_tx_en),
        .an_pause_rx_i(an_pause_rx_i),
        .an_pause_tx_i(an_pause_tx_i),
        .duplex_now_o(next_duplex_now),
        .pause_rx_now_o(next_pause_rx_now),
        .pause_tx_now_o(next_pause_tx_now)
    );

    // status flops, one cycle behind the inputs they follow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port1_duplex_now <= rst_duplex_now;
            port1_pause_rx_now <= rst_pause_rx_now;
            port1_pause_tx_now <= rst_pause_tx_now;
        end else if (ce_i) begin
            port1_duplex_now <= next_duplex_now;
            port1_pause_rx_now <= next_pause_rx_now;
            port1_pause_tx_now <= next_pause_tx_now;
        end
    end

    // read word: in-force settings plus stored controls, reserved as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[31:FIELD_TOP+1] = RESERVED_READ;
        rd_word[BIT_BACKPRESSURE_EN] = port1_backpressure_en;
        rd_word[BIT_DUPLEX_NOW] = port1_duplex_now;
        rd_word[BIT_PAUSE_RX_NOW] = port1_pause_rx_now;
        rd_word[BIT_PAUSE_TX_NOW] = port1_pause_tx_now;
        rd_word[BIT_PAUSE_RX_EN] = port1_pause_rx_en;
        rd_word[BIT_PAUSE_TX_EN] = port1_pause_tx_en;
        rd_word[BIT_MANUAL_SELECT] = port1_manual_select;
    end

    // one-cycle ack; unmapped addresses ack with zero and drop writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= hit ? rd_word : 32'h0000_0000;
            end
        end
    end

    // the phy advertisement register has no path from here, by design
    assign port1_backpressure_en_o = port1_backpressure_en;
    assign port1_pause_rx_now_o = port1_pause_rx_now;
    assign port1_pause_tx_now_o = port1_pause_tx_now;
    assign port1_duplex_now_o = port1_duplex_now;

    // checks on the behaviour above
    logic rd_hit_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_hit_q <= 1'b0;
        end else if (ce_i) begin
            rd_hit_q <= req & ~wb_we_i & hit;
        end
    end

    bp_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_low && ce_i && !loader_load_i |=>
            port1_backpressure_en_o == $past(wb_dat_i[BIT_BACKPRESSURE_EN]))
        else $error("backpressure enable did not follow the write");

    // the reset edge itself is kept out: status then holds the strap values
    duplex_track_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i |=> port1_duplex_now_o == !$past(link_full_duplex_i))
        else $error("duplex status does not follow the link");

    rx_manual_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && port1_manual_select && link_full_duplex_i |=>
            port1_pause_rx_now_o == $past(port1_pause_rx_en))
        else $error("manual receive pause not applied");

    tx_manual_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && port1_manual_select && link_full_duplex_i |=>
            port1_pause_tx_now_o == $past(port1_pause_tx_en))
        else $error("manual transmit pause not applied");

    neg_result_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && !port1_manual_select && autoneg_en_i |=>
            port1_pause_rx_now_o == $past(an_pause_rx_i && link_full_duplex_i) &&
            port1_pause_tx_now_o == $past(an_pause_tx_i && link_full_duplex_i))
        else $error("negotiated pause not applied");

    no_neg_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && !port1_manual_select && !autoneg_en_i && link_full_duplex_i |=>
            port1_pause_rx_now_o == $past(port1_pause_rx_en) &&
            port1_pause_tx_now_o == $past(port1_pause_tx_en))
        else $error("stored enable ignored without negotiation");

    half_no_pause_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && ce_i && !link_full_duplex_i |=>
            !port1_pause_rx_now_o && !port1_pause_tx_now_o)
        else $error("pause active in half duplex");

    strap_reset_a: assert property (
        @(posedge clk_i)
        $fell(rst_i) |->
            port1_backpressure_en_o == $past(strap_sync[STRAP_BACKPRESSURE]) &&
            port1_manual_select == $past(strap_sync[STRAP_MANUAL_SELECT]))
        else $error("writable bits not loaded from straps");

    // status reset: duplex from its strap, pause only with pause and full duplex straps
    status_reset_a: assert property (
        @(posedge clk_i)
        $fell(rst_i) |->
            port1_duplex_now_o == !$past(strap_sync[STRAP_FULL_DUPLEX]) &&
            port1_pause_rx_now_o == $past(strap_sync[STRAP_PAUSE_ENABLE] &&
                strap_sync[STRAP_FULL_DUPLEX]))
        else $error("status bits not loaded from the straps");

    // a write without byte lane 0 must leave the stored controls alone
    lane_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i && !wb_sel_i[0] && ce_i && !loader_load_i |=>
            $stable(port1_backpressure_en) && $stable(port1_manual_select))
        else $error("write with lane 0 off changed the register");

    loader_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        loader_load_i && ce_i |=>
            port1_pause_rx_en == $past(loader_pause_enable_i) &&
            port1_backpressure_en_o == $past(loader_backpressure_i))
        else $error("loader rewrite not taken");

    read_back_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && rd_hit_q && $past(ce_i) |->
            wb_dat_o[BIT_PAUSE_TX_NOW] == $past(port1_pause_tx_now))
        else $error("read data does not show transmit pause state");

    reserved_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:FIELD_TOP+1] == '0)
        else $error("reserved bits read nonzero");

    ack_once_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    ack_next_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req && ce_i |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");

    manual_wr_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_low && wb_dat_i[BIT_MANUAL_SELECT]);
    neg_mode_c: cover property (@(posedge clk_i) disable iff (rst_i)
        !port1_manual_select && autoneg_en_i && port1_pause_rx_now_o);
    loader_c: cover property (@(posedge clk_i) disable iff (rst_i) loader_load_i && ce_i);
    read_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_ack_o && rd_hit_q);
    manual_reset_c: cover property (@(posedge clk_i) $fell(rst_i) && port1_manual_select);
endmodule
`default_nettype wire

// *** test/pfc_link_model.sv ***
// link partner model: duplex and negotiated pause seen on port 1
`timescale 1ns/1ps
`default_nettype none
module pfc_link_model (
    input wire logic clk_i,
    input wire logic [3:0] mode_i, // autoneg, full duplex, partner rx, partner tx
    output logic autoneg_en_o,
    output logic full_duplex_o,
    output logic an_pause_rx_o,
    output logic an_pause_tx_o
);
    // registered, so link changes reach the block one edge late like a real phy
    always_ff @(posedge clk_i) begin
        {autoneg_en_o, full_duplex_o, an_pause_rx_o, an_pause_tx_o} <= mode_i;
    end
endmodule
`default_nettype wire

// *** test/pfc_regs_tb.sv ***
// self-checking testbench for the port 1 flow-control register block
`timescale 1ns/1ps
`default_nettype none
module pfc_regs_tb import pfc_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ld = 1'b0, ce = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd;
    logic ack, bp_o, rx_o, tx_o, dup_o, an_w, fd_w, arx_w, atx_w;
    logic [4:0] strap = 5'h1b; // autoneg, full duplex, no manual, pause, backpressure
    logic [2:0] ldv = 3'h0; // loader backpressure, pause, manual
    logic [3:0] link = 4'h0; // half duplex, no negotiation while in reset
    int fails = 0;
    int tests_run = 0;

    always #12.5 clk_i = ~clk_i;

    pfc_link_model pfc_link_model_i (.clk_i(clk_i), .mode_i(link), .autoneg_en_o(an_w),
        .full_duplex_o(fd_w), .an_pause_rx_o(arx_w), .an_pause_tx_o(atx_w));

    pfc_regs pfc_regs_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .backpressure_strap_i(strap[0]), .pause_enable_strap_i(strap[1]),
        .manual_select_strap_i(strap[2]), .full_duplex_strap_i(strap[3]),
        .autoneg_strap_i(strap[4]), .loader_load_i(ld), .loader_backpressure_i(ldv[2]),
        .loader_pause_enable_i(ldv[1]), .loader_manual_select_i(ldv[0]),
        .autoneg_en_i(an_w), .link_full_duplex_i(fd_w), .an_pause_rx_i(arx_w),
        .an_pause_tx_i(atx_w), .port1_backpressure_en_o(bp_o),
        .port1_pause_rx_now_o(rx_o), .port1_pause_tx_now_o(tx_o),
        .port1_duplex_now_o(dup_o));

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic cycle; the idle edge first keeps back-to-back calls apart
    task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge clk_i);
        if (n == 20) begin
            fails++;
            test_done();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // expected word: {backpressure, rx, tx, manual} config and link {an, fd, an rx, an tx}
    function automatic logic [31:0] expv(input logic [3:0] cf, input logic [3:0] lk);
        logic rx, tx;
        rx = (lk[3] && !cf[0]) ? lk[1] : cf[2];
        tx = (lk[3] && !cf[0]) ? lk[0] : cf[1];
        return {25'h000_0000, cf[3], ~lk[2], rx & lk[2], tx & lk[2], cf[2:0]};
    endfunction

    // read back the register and compare it and the mac controls with the expected word
    task automatic look(input string nm, input logic [31:0] e);
        wb(1'b0, PORT1_FLOW_CONTROL_CONFIG_OFS, 32'h0000_0000, 4'h1);
        chk(nm, rd, e);
        chk("mac controls", {28'h000_0000, bp_o, dup_o, rx_o, tx_o}, {28'h000_0000, e[6:3]});
    endtask

    initial begin
        logic [3:0] cf, lk;
        logic [31:0] e, d;
        logic [2:0] l;
        repeat (3) @(posedge clk_i);
        #1;
        // status follows the straps here, not the half-duplex link
        chk("reset controls", {bp_o, dup_o, rx_o, tx_o}, 32'h0000_000b);
        @(posedge clk_i);
        rst_i <= 1'b0;
        look("after reset", expv(4'b1110, 4'h0));
        // 32 mode mixes covering all 16 configs and all 16 link modes; status and reserved bits written inverted to catch leaks
        for (int i = 0; i < 32; i++) begin
            cf = i[3:0];
            lk = {i[4], i[0] ^ i[2], ~i[1], i[3] ^ i[0]};
            e = expv(cf, lk);
            d = {25'h1ff_ffff, cf[3], ~e[5:3], cf[2:0]};
            link <= lk;
            wb(1'b1, PORT1_FLOW_CONTROL_CONFIG_OFS, d, 4'h1);
            look("config", e);
        end
        wb(1'b1, PORT1_FLOW_CONTROL_CONFIG_OFS, 32'h0000_0000, 4'he);
        look("lane off write", e);
        wb(1'b1, 12'h1a4, 32'h0000_0000, 4'h1);
        look("unmapped write", e);
        wb(1'b0, 12'h1a4, 32'h0000_0000, 4'h1);
        chk("unmapped read", rd, 32'h0000_0000);
        // loader rewrites land in the register, also while negotiation rules
        for (int j = 0; j < 2; j++) begin
            l = j[0] ? 3'b101 : 3'b010;
            @(posedge clk_i);
            ldv <= l;
            ld <= 1'b1;
            @(posedge clk_i);
            ld <= 1'b0;
            look("loader", expv({l[2], l[1], l[1], l[0]}, lk));
        end
        // clock enable low: a loader pulse in that cycle must not land
        @(posedge clk_i);
        ce <= 1'b0;
        ldv <= 3'b010;
        ld <= 1'b1;
        @(posedge clk_i);
        ld <= 1'b0;
        ce <= 1'b1;
        look("frozen", expv({l[2], l[1], l[1], l[0]}, lk));
        // second reset with new straps: manual, pause, half duplex, no backpressure
        strap <= 5'h06;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("mid reset controls", {bp_o, dup_o, rx_o, tx_o}, 32'h0000_0004);
        @(posedge clk_i);
        rst_i <= 1'b0;
        look("mid reset", expv(4'b0111, lk));
        test_done();
    end
endmodule
`default_nettype wire
